/* File: profile_mem.sv */
// byte memory holding the segment tables, registered read
`timescale 1ns/1ns
`default_nettype none
module profile_mem #(
    parameter int AW = pulse_gen_pkg::MEM_AW
) (
    input wire logic pclk,
    input wire logic ce,
    input wire pulse_gen_pkg::mem_wr_t wr,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    import pulse_gen_pkg::*;

    logic [7:0] mem_ff [0:(1<<AW)-1];

    // no reset on the array: contents are software data
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (wr.we) begin
                mem_ff[wr.waddr] <= wr.wdata;
            end
            rdata <= mem_ff[raddr];
        end
    end
endmodule
`default_nettype wire

/* File: pulse_gen.sv */
// three-channel pulse train / variable duty generator with apb registers
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module pulse_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pulse_gen_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic follow_in,
    output logic pulse_out_0,
    output logic pulse_out_1,
    output logic pulse_out_2
);
    import pulse_gen_pkg::*;

    // *****************************************************************
    // state
    // *****************************************************************
    typedef struct packed {
        chan_cfg_t [CH_NUM-1:0] cfg;
        chan_t [CH_NUM-1:0] ch;
        fetch_t f;
        logic [CH_NUM-1:0] dout;
        logic [CH_NUM-1:0] pin;
        logic [3:0] us_cnt;
        logic [9:0] ms_cnt;
        logic us_tick;
        logic ms_tick;
        logic fin_prev;
        logic [31:0] rdata;
        logic slverr;
    } state_t;

    state_t s_ff;
    state_t nxt_s;
    logic [7:0] mem_rdata;
    mem_wr_t mem_wr;

    // channel index of a per-channel register, CH_NUM if none
    function automatic logic [1:0] dec_ch(input logic [ADDR_W-1:0] a);
        logic [1:0] r;
        r = 2'(CH_NUM);
        if (a < ADDR_W'(CH_NUM) * CH_STRIDE) begin
            r = 2'(a / CH_STRIDE);
        end
        return r;
    endfunction

    function automatic logic [4:0] dec_off(input logic [ADDR_W-1:0] a);
        return 5'(a % CH_STRIDE);
    endfunction

    // *****************************************************************
    // profile memory
    // *****************************************************************
    profile_mem #(.AW(MEM_AW)) u_mem (
        .pclk(pclk),
        .ce(ce),
        .wr(mem_wr),
        .raddr(s_ff.f.addr),
        .rdata(mem_rdata)
    );

    always_comb begin
        // one bit wider: the window ends at the top of the map
        mem_wr.we = psel & penable & pwrite & ce &
            (paddr >= ADDR_MEM) &
            (14'(paddr) < 14'(ADDR_MEM) + 14'(4 << MEM_AW));
        mem_wr.waddr = MEM_AW'((paddr - ADDR_MEM) >> 2);
        mem_wr.wdata = pwdata[7:0];
    end

    // *****************************************************************
    // next state
    // *****************************************************************
    always_comb begin
        logic wr;
        logic rise;
        logic tick;
        logic found;
        logic [1:0] sel;
        logic [1:0] c;
        logic [4:0] off;
        logic [CH_NUM-1:0] start_vec;
        logic [16:0] nxt_cnt;
        logic [32:0] sum;
        wr = 1'b0;
        rise = 1'b0;
        tick = 1'b0;
        found = 1'b0;
        sel = 2'h0;
        c = 2'h0;
        off = 5'h00;
        start_vec = '0;
        nxt_cnt = 17'h00000;
        sum = 33'h000000000;
        nxt_s = s_ff;

        // time base ticks shared by all channels
        nxt_s.us_tick = 1'b0;
        nxt_s.ms_tick = 1'b0;
        if (s_ff.us_cnt == 4'(US_CYC - 1)) begin
            nxt_s.us_cnt = 4'h0;
            nxt_s.us_tick = 1'b1;
            if (s_ff.ms_cnt == 10'(MS_US - 1)) begin
                nxt_s.ms_cnt = 10'h000;
                nxt_s.ms_tick = 1'b1;
            end else begin
                nxt_s.ms_cnt = s_ff.ms_cnt + 10'h001;
            end
        end else begin
            nxt_s.us_cnt = s_ff.us_cnt + 4'h1;
        end
        nxt_s.fin_prev = follow_in;
        rise = follow_in & ~s_ff.fin_prev;

        // apb: read data captured in setup, answered in access
        sel = dec_ch(paddr);
        off = dec_off(paddr);
        wr = psel & penable & pwrite;
        if (psel & ~penable) begin
            nxt_s.rdata = 32'h00000000;
            nxt_s.slverr = 1'b0;
            if (sel != 2'(CH_NUM)) begin
                case (off)
                    OFF_CTRL: nxt_s.rdata = 32'(s_ff.cfg[sel].ctrl);
                    OFF_PERIOD: nxt_s.rdata = 32'(s_ff.cfg[sel].period);
                    OFF_WIDTH: nxt_s.rdata = 32'(s_ff.cfg[sel].width);
                    OFF_COUNT: nxt_s.rdata = s_ff.cfg[sel].count;
                    OFF_BASE: nxt_s.rdata = 32'(s_ff.cfg[sel].base);
                    OFF_GEAR: nxt_s.rdata = s_ff.cfg[sel].gear;
                    OFF_STATUS: nxt_s.rdata = {27'h0000000,
                        s_ff.ch[sel].done, s_ff.ch[sel].active,
                        s_ff.ch[sel].err, s_ff.ch[sel].pwm_idle,
                        s_ff.ch[sel].pto_idle};
                    default: nxt_s.slverr = 1'b1;
                endcase
            end else if (paddr == ADDR_DOUT) begin
                nxt_s.rdata = 32'(s_ff.dout);
            end else if (paddr == ADDR_START) begin
                nxt_s.rdata = 32'h00000000;
            end else if (paddr < ADDR_MEM ||
                    14'(paddr) >= 14'(ADDR_MEM) + 14'(4 << MEM_AW)) begin
                nxt_s.slverr = 1'b1;
            end
        end
        if (wr) begin
            if (sel != 2'(CH_NUM)) begin
                case (off)
                    OFF_CTRL: nxt_s.cfg[sel].ctrl = pwdata[4:0];
                    OFF_PERIOD: nxt_s.cfg[sel].period = pwdata[15:0];
                    OFF_WIDTH: nxt_s.cfg[sel].width = pwdata[15:0];
                    OFF_COUNT: nxt_s.cfg[sel].count = pwdata;
                    OFF_BASE: nxt_s.cfg[sel].base = pwdata[15:0];
                    OFF_GEAR: nxt_s.cfg[sel].gear = pwdata;
                    default: nxt_s.cfg[sel] = s_ff.cfg[sel];
                endcase
            end else if (paddr == ADDR_DOUT) begin
                nxt_s.dout = pwdata[CH_NUM-1:0];
            end else if (paddr == ADDR_START &&
                    pwdata[1:0] < 2'(CH_NUM)) begin
                // selector 3 is undefined and dropped
                start_vec[pwdata[1:0]] = 1'b1;
            end
        end

        // *****************************************************************
        // channel engines
        // *****************************************************************
        for (int i = 0; i < CH_NUM; i++) begin
            tick = s_ff.ch[i].tb_ms ? s_ff.ms_tick : s_ff.us_tick;
            if (start_vec[i]) begin
                nxt_s.ch[i] = '0;
                nxt_s.ch[i].tb_ms = s_ff.cfg[i].ctrl[CTL_TB];
                nxt_s.ch[i].pwm = s_ff.cfg[i].ctrl[CTL_PWM];
                nxt_s.ch[i].multi = s_ff.cfg[i].ctrl[CTL_MULTI];
                nxt_s.ch[i].follow = s_ff.cfg[i].ctrl[CTL_FOLLOW];
                nxt_s.ch[i].period = s_ff.cfg[i].period;
                nxt_s.ch[i].width = s_ff.cfg[i].width;
                nxt_s.ch[i].left = s_ff.cfg[i].count;
                nxt_s.ch[i].ptr = MEM_AW'(s_ff.cfg[i].base);
                nxt_s.ch[i].pto_idle = 1'b1;
                nxt_s.ch[i].pwm_idle = 1'b1;
                if (!s_ff.cfg[i].ctrl[CTL_EN]) begin
                    nxt_s.ch[i].active = 1'b0;
                end else if (s_ff.cfg[i].ctrl[CTL_FOLLOW]) begin
                    if (s_ff.cfg[i].gear[31:16] == 16'h0000 ||
                            s_ff.cfg[i].count == 32'h00000000) begin
                        nxt_s.ch[i].err = 1'b1;
                    end else begin
                        nxt_s.ch[i].active = 1'b1;
                        nxt_s.ch[i].pto_idle = 1'b0;
                    end
                end else if (s_ff.cfg[i].ctrl[CTL_PWM]) begin
                    nxt_s.ch[i].active = 1'b1;
                    nxt_s.ch[i].pwm_idle = 1'b0;
                end else if (s_ff.cfg[i].ctrl[CTL_MULTI]) begin
                    nxt_s.ch[i].active = 1'b1;
                    nxt_s.ch[i].need = 1'b1;
                    nxt_s.ch[i].hdr = 1'b1;
                    nxt_s.ch[i].pto_idle = 1'b0;
                end else if (s_ff.cfg[i].period < 16'h0002 ||
                        s_ff.cfg[i].count < 32'h00000002) begin
                    nxt_s.ch[i].err = 1'b1;
                end else begin
                    nxt_s.ch[i].active = 1'b1;
                    nxt_s.ch[i].pto_idle = 1'b0;
                    nxt_s.ch[i].out = 1'b1;
                end
            end else if (s_ff.ch[i].active && !s_ff.ch[i].need) begin
                if (s_ff.ch[i].follow) begin
                    // twice num per input edge, one half pulse per den
                    sum = s_ff.ch[i].acc;
                    if (rise) begin
                        sum = sum + {s_ff.cfg[i].gear[15:0], 1'b0};
                    end
                    if (sum >= 33'(s_ff.cfg[i].gear[31:16])) begin
                        sum = sum - 33'(s_ff.cfg[i].gear[31:16]);
                        nxt_s.ch[i].out = ~s_ff.ch[i].out;
                        if (s_ff.ch[i].out) begin
                            nxt_s.ch[i].left = s_ff.ch[i].left - 32'h1;
                            if (s_ff.ch[i].left == 32'h00000001) begin
                                nxt_s.ch[i].active = 1'b0;
                                nxt_s.ch[i].done = 1'b1;
                                nxt_s.ch[i].pto_idle = 1'b1;
                            end
                        end
                    end
                    nxt_s.ch[i].acc = sum;
                end else if (s_ff.ch[i].pwm) begin
                    if (tick) begin
                        nxt_cnt = {1'b0, s_ff.ch[i].unit_cnt} + 17'h1;
                        nxt_s.ch[i].unit_cnt = (nxt_cnt >=
                            {1'b0, s_ff.ch[i].period}) ?
                            16'h0000 : nxt_cnt[15:0];
                    end
                    if (s_ff.ch[i].width > s_ff.ch[i].period) begin
                        nxt_s.ch[i].out = 1'b1;
                    end else if (s_ff.ch[i].width == 16'h0000) begin
                        nxt_s.ch[i].out = 1'b0;
                    end else begin
                        nxt_s.ch[i].out =
                            nxt_s.ch[i].unit_cnt < s_ff.ch[i].width;
                    end
                end else if (tick) begin
                    nxt_cnt = {1'b0, s_ff.ch[i].unit_cnt} + 17'h1;
                    if (nxt_cnt >= {1'b0, s_ff.ch[i].period}) begin
                        nxt_s.ch[i].unit_cnt = 16'h0000;
                        nxt_s.ch[i].left = s_ff.ch[i].left - 32'h1;
                        if (s_ff.ch[i].left == 32'h00000001) begin
                            if (s_ff.ch[i].multi &&
                                    s_ff.ch[i].seg_left != 8'h00) begin
                                nxt_s.ch[i].need = 1'b1;
                            end else begin
                                nxt_s.ch[i].active = 1'b0;
                                nxt_s.ch[i].done = 1'b1;
                                nxt_s.ch[i].pto_idle = 1'b1;
                            end
                        end
                    end else begin
                        nxt_s.ch[i].unit_cnt = nxt_cnt[15:0];
                    end
                    // high for the first half of each period
                    nxt_s.ch[i].out = nxt_s.ch[i].unit_cnt <
                        (s_ff.ch[i].period >> 1);
                end
            end
            if (!nxt_s.ch[i].active || nxt_s.ch[i].need) begin
                nxt_s.ch[i].out = 1'b0;
            end
        end

        // *****************************************************************
        // segment fetcher, one channel at a time
        // *****************************************************************
        for (int i = CH_NUM - 1; i >= 0; i--) begin
            if (s_ff.ch[i].need) begin
                found = 1'b1;
                c = 2'(i);
            end
        end
        case ((s_ff.f.st != F_IDLE && start_vec[s_ff.f.ch]) ?
                F_IDLE : s_ff.f.st)
            F_IDLE: begin
                if (found) begin
                    nxt_s.f.ch = c;
                    nxt_s.f.addr = s_ff.ch[c].ptr;
                    nxt_s.f.b = 3'h0;
                    nxt_s.f.st = s_ff.ch[c].hdr ? F_HDR : F_RD;
                end
            end
            F_HDR: nxt_s.f.st = F_HDR_TAKE;
            F_HDR_TAKE: begin
                c = s_ff.f.ch;
                if (mem_rdata == 8'h00 || mem_rdata > SEG_MAX) begin
                    nxt_s.ch[c].err = 1'b1;
                    nxt_s.ch[c].active = 1'b0;
                    nxt_s.ch[c].need = 1'b0;
                    nxt_s.ch[c].pto_idle = 1'b1;
                    nxt_s.f.st = F_IDLE;
                end else begin
                    nxt_s.ch[c].seg_left = mem_rdata;
                    nxt_s.ch[c].hdr = 1'b0;
                    nxt_s.f.addr = s_ff.f.addr + MEM_AW'(1);
                    nxt_s.f.st = F_RD;
                end
            end
            F_RD: nxt_s.f.st = F_TAKE;
            F_TAKE: begin
                c = s_ff.f.ch;
                // bytes taken little endian
                if (s_ff.f.b < SEG_RSV_LO) begin
                    nxt_s.f.per = {mem_rdata, s_ff.f.per[15:8]};
                end else begin
                    nxt_s.f.cnt = {mem_rdata, s_ff.f.cnt[31:8]};
                end
                nxt_s.f.st = F_RD;
                if (s_ff.f.b == SEG_RSV_LO - 3'h1) begin
                    // reserved word never read
                    nxt_s.f.b = SEG_CNT_LO;
                    nxt_s.f.addr = s_ff.f.addr + MEM_AW'(3);
                end else begin
                    nxt_s.f.b = s_ff.f.b + 3'h1;
                    nxt_s.f.addr = s_ff.f.addr + MEM_AW'(1);
                end
                if (s_ff.f.b == SEG_LAST) begin
                    nxt_s.f.st = F_IDLE;
                    nxt_s.ch[c].need = 1'b0;
                    nxt_s.ch[c].ptr = s_ff.f.addr + MEM_AW'(1);
                    nxt_s.ch[c].seg_left = s_ff.ch[c].seg_left - 8'h01;
                    nxt_s.ch[c].unit_cnt = 16'h0000;
                    nxt_s.ch[c].period = s_ff.f.per;
                    nxt_s.ch[c].left = {mem_rdata, s_ff.f.cnt[31:8]};
                    nxt_s.ch[c].out = 1'b1;
                    if (s_ff.f.per < 16'h0002 ||
                            s_ff.f.cnt[31:8] == 24'h000000 &&
                            mem_rdata == 8'h00) begin
                        nxt_s.ch[c].err = 1'b1;
                        nxt_s.ch[c].active = 1'b0;
                        nxt_s.ch[c].out = 1'b0;
                        nxt_s.ch[c].pto_idle = 1'b1;
                    end
                end
            end
            default: nxt_s.f.st = F_IDLE;
        endcase
        // a restart abandons a fetch in flight
        if (s_ff.f.st != F_IDLE && start_vec[s_ff.f.ch]) begin
            nxt_s.f.st = F_IDLE;
        end

        // pin ownership
        for (int i = 0; i < CH_NUM; i++) begin
            nxt_s.pin[i] = s_ff.ch[i].active ?
                s_ff.ch[i].out : s_ff.dout[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // *****************************************************************
    // outputs
    // *****************************************************************
    always_comb begin
        pready = ce;
        prdata = s_ff.rdata;
        pslverr = s_ff.slverr & psel & penable;
        pulse_out_0 = s_ff.pin[0];
        pulse_out_1 = s_ff.pin[1];
        pulse_out_2 = s_ff.pin[2];
    end
endmodule
`default_nettype wire

/* File: pulse_gen_asserts.sv */
// port-level checker of the pulse generator
`timescale 1ns/1ns
`default_nettype none
module pulse_gen_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [12:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pulse_out_0,
    input wire logic pulse_out_1,
    input wire logic pulse_out_2
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic setup = psel && !penable && ce;
    wire logic acc = psel && penable;
    rdy_tracks_ce_a: assert property (pready == ce)
        else $error("pready differs from ce");
    err_in_access_a: assert property (pslverr |-> acc)
        else $error("pslverr outside access phase");
    pin_freeze_a: assert property (!ce |=>
        $stable({pulse_out_0, pulse_out_1, pulse_out_2}))
        else $error("pin moved while ce low");
    rd_hold_a: assert property (!setup |=> $stable(prdata))
        else $error("prdata changed outside setup");
    unmapped_err_a: assert property (setup && paddr == 13'h0ffc ##1 acc
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    dout_ok_a: assert property (setup && paddr == 13'h0064 ##1 acc
        |-> !pslverr)
        else $error("mapped access refused");
    mem_wo_a: assert property (setup && !pwrite && paddr[12] ##1 acc
        |-> prdata == 32'h0 && !pslverr)
        else $error("profile memory read not zero");
    idle_after_rst_a: assert property ($rose(presetn) |->
        !pulse_out_0 && !pulse_out_1 && !pulse_out_2)
        else $error("pin high after reset");
endmodule
bind pulse_gen pulse_gen_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_out_0(pulse_out_0), .pulse_out_1(pulse_out_1),
    .pulse_out_2(pulse_out_2));
`default_nettype wire

/* File: pulse_gen_pkg.sv */
// constants, register map and state types of the pulse train generator
//
// Functional notes
// - start command selects channel 0, 1 or 2
// - start loads channel config, then pulses until done
// - active generator overrides the plain output value
// - variable-duty mode: independent period and high time
// - times in us or ms units, 16-bit period
// - high time above period gives constant high
// - zero high time gives constant low
// - train mode: 50% square wave, counted pulses
// - single train count below 2 flags error, no output
// - single train runs once per start
// - multi-segment fetches segments in order from memory
// - segment is period, reserved word, 32-bit count
// - period changes only at segment boundaries
// - per-channel profile base and time base select
// - table byte 0 is segment count 1..64
// - period at offset 1, count at 5, next at 9
// - follow mode scales input by gear ratio, stops at count
// - per-channel train and duty idle flags
package pulse_gen_pkg;
    // *****************************************************************
    // sizes and timing
    // *****************************************************************
    localparam int CH_NUM = 3;
    localparam int ADDR_W = 13;
    localparam int MEM_AW = 10;
    localparam int CLK_NS = 100;
    localparam int TB_US_NS = 1000;
    localparam int US_CYC = (TB_US_NS + CLK_NS - 1) / CLK_NS;
    localparam int MS_US = 1000;
    localparam logic [7:0] SEG_MAX = 8'h40;
    localparam logic [2:0] SEG_RSV_LO = 3'h2;
    localparam logic [2:0] SEG_CNT_LO = 3'h4;
    localparam logic [2:0] SEG_LAST = 3'h7;

    // *****************************************************************
    // register map
    // *****************************************************************
    localparam logic [ADDR_W-1:0] CH_STRIDE = 13'h0020;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_PERIOD = 5'h04;
    localparam logic [4:0] OFF_WIDTH = 5'h08;
    localparam logic [4:0] OFF_COUNT = 5'h0c;
    localparam logic [4:0] OFF_BASE = 5'h10;
    localparam logic [4:0] OFF_STATUS = 5'h14;
    localparam logic [4:0] OFF_GEAR = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_START = 13'h0060;
    localparam logic [ADDR_W-1:0] ADDR_DOUT = 13'h0064;
    localparam logic [ADDR_W-1:0] ADDR_MEM = 13'h1000;

    localparam int CTL_TB = 0;
    localparam int CTL_MULTI = 1;
    localparam int CTL_PWM = 2;
    localparam int CTL_FOLLOW = 3;
    localparam int CTL_EN = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // *****************************************************************
    // types
    // *****************************************************************
    typedef struct packed {
        logic [4:0] ctrl;
        logic [15:0] period;
        logic [15:0] width;
        logic [31:0] count;
        logic [15:0] base;
        logic [31:0] gear;
    } chan_cfg_t;

    typedef struct packed {
        logic active;
        logic out;
        logic tb_ms;
        logic pwm;
        logic multi;
        logic follow;
        logic pto_idle;
        logic pwm_idle;
        logic err;
        logic done;
        logic need;
        logic hdr;
        logic [15:0] unit_cnt;
        logic [15:0] period;
        logic [15:0] width;
        logic [31:0] left;
        logic [7:0] seg_left;
        logic [MEM_AW-1:0] ptr;
        logic [32:0] acc;
    } chan_t;

    typedef enum logic [2:0] {
        F_IDLE,
        F_HDR,
        F_HDR_TAKE,
        F_RD,
        F_TAKE
    } fetch_st_t;

    typedef struct packed {
        fetch_st_t st;
        logic [1:0] ch;
        logic [2:0] b;
        logic [MEM_AW-1:0] addr;
        logic [15:0] per;
        logic [31:0] cnt;
    } fetch_t;

    typedef struct packed {
        logic we;
        logic [MEM_AW-1:0] waddr;
        logic [7:0] wdata;
    } mem_wr_t;
endpackage

/* File: pulse_sink.sv */
// drive-side model: counts pulses and times the last high phase
`timescale 1ns/1ns
`default_nettype none
module pulse_sink (
    input wire logic clk,
    input wire logic pin,
    output int rises,
    output int hi_len
);
    int run = 0;
    logic last = 1'b0;
    initial rises = 0;
    initial hi_len = 0;
    // a drive only sees edges, so widths are whole clock counts
    always @(posedge clk) begin
        if (pin && !last)
            rises <= rises + 1;
        if (!pin && last)
            hi_len <= run;
        run <= (pin != last) ? 1 : run + 1;
        last <= pin;
    end
endmodule
`default_nettype wire

/* File: tb_pulse_train_pwm_generator.sv */
// self-checking bench of the pulse generator
`timescale 1ns/1ns
`default_nettype none
module tb_pulse_train_pwm_generator;
    import pulse_gen_pkg::*;
    typedef struct {logic [12:0] a; logic [31:0] d, e; logic er;} row_t;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, fin = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [2:0] pin;
    int rises [3], hi [3], r, n_fail = 0, compares = 0;
    row_t rows [6];
    logic [7:0] tbl [17] = '{8'h02, 8'h02, 8'h00, 8'hff, 8'hff, 8'h02, 8'h00,
        8'h00, 8'h00, 8'h04, 8'h00, 8'haa, 8'h55, 8'h02, 8'h00, 8'h00, 8'h00};
    always #50 pclk = ~pclk;
    pulse_gen u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .follow_in(fin), .pulse_out_0(pin[0]), .pulse_out_1(pin[1]),
        .pulse_out_2(pin[2]));
    for (genvar i = 0; i < 3; i++) begin : g_sink
        pulse_sink u_sink (.clk(pclk), .pin(pin[i]), .rises(rises[i]),
            .hi_len(hi[i]));
    end
    function automatic logic [12:0] ra(int ch, logic [4:0] off);
        return ADDR_W'(ch * CH_STRIDE + off);
    endfunction
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [12:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready may stay low while ce is low, so wait for it
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic go(int ch, logic [4:0] ctl, int per, int wid, int cnt);
        apb(1, ra(ch, OFF_PERIOD), per);
        apb(1, ra(ch, OFF_WIDTH), wid);
        apb(1, ra(ch, OFF_COUNT), cnt);
        apb(1, ra(ch, OFF_CTRL), 32'(ctl));
        r = rises[ch];
        apb(1, ADDR_START, ch);
    endtask
    task automatic wait_st(int ch, int b);
        for (int n = 0; n < 500 && rd[b] !== 1'b1; n++)
            apb(0, ra(ch, OFF_STATUS), 0);
    endtask
    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        close_out();
    end
    initial begin
        rows = '{'{ra(0, OFF_PERIOD), 32'h1234abcd, 32'habcd, 0},
            '{ra(1, OFF_COUNT), '1, '1, 0}, '{ra(2, OFF_CTRL), 32'hff, 32'h1f, 0},
            '{ra(0, OFF_GEAR), 32'h30002, 32'h30002, 0},
            '{13'h0ffc, 32'h1, 32'h0, 1}, '{ADDR_MEM, 32'h5a, 32'h0, 0}};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ra(0, OFF_STATUS), 0);
        chk("status after reset", rd, 0);
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d);
            apb(0, rows[i].a, 0);
            chk("readback", rd, rows[i].e);
            chk("pslverr", 32'(err), 32'(rows[i].er));
        end
        // ****************************************************************
        // pulse scenarios, all in the microsecond base of 10 clocks
        // ****************************************************************
        go(0, 5'h10, 4, 0, 3);
        wait_st(0, 0);
        chk("train pulses", rises[0] - r, 3);
        chk("train high", hi[0], 20);
        chk("pin after train", pin, 0);
        apb(1, ADDR_START, 3);
        repeat (100) @(posedge pclk);
        chk("selector three", rises[0] - r, 3);
        go(1, 5'h10, 4, 0, 1);
        wait_st(1, 2);
        chk("short count", rises[1] - r, 0);
        apb(1, ra(1, OFF_GEAR), 32'h00010001);
        go(1, 5'h18, 0, 0, 2);
        repeat (3) begin
            fin <= 1'b1;
            repeat (4) @(posedge pclk);
            fin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        chk("follow pulses", rises[1] - r, 2);
        apb(0, ra(1, OFF_STATUS), 0);
        chk("follow done", rd[4], 1);
        go(2, 5'h14, 4, 1, 0);
        repeat (100) @(posedge pclk);
        ce <= 1'b0;
        repeat (5) @(posedge pclk);
        ce <= 1'b1;
        repeat (100) @(posedge pclk);
        chk("duty high", hi[2], 10);
        apb(1, ADDR_DOUT, 4);
        for (int w = 0; w < 2; w++) begin
            go(2, 5'h14, 4, 5 * w, 0);
            repeat (100) @(posedge pclk);
            r = rises[2];
            repeat (100) @(posedge pclk);
            chk("flat duty pin", pin[2], w);
            chk("flat duty edges", rises[2] - r, 0);
        end
        go(2, 5'h00, 4, 0, 0);
        repeat (10) @(posedge pclk);
        chk("pin released", pin[2], 1);
        foreach (tbl[i])
            apb(1, ADDR_MEM + 13'(4 * (i + 1)), 32'(tbl[i]));
        apb(1, ra(0, OFF_BASE), 1);
        go(0, 5'h12, 0, 0, 0);
        wait_st(0, 0);
        chk("segment pulses", rises[0] - r, 4);
        chk("segment two high", hi[0], 20);
        close_out();
    end
endmodule
`default_nettype wire
